// ---- rtl/ddr_start_training_map.svh ----
// Purpose: Offsets, field positions and reset values of the training/command block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef DDR_START_TRAINING_MAP_SVH
`define DDR_START_TRAINING_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DTC_OFF_CTRL        12'h050
`define DTC_OFF_PARAMS      12'h058
`define DTC_OFF_CMD         12'h060
`define DTC_OFF_STATUS      12'h064

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DTC_CTRL_START_TRAINING      0
`define DTC_CTRL_IMP_CAL    1
`define DTC_CTRL_ZQ_CAL     2
`define DTC_CTRL_INIT_DONE  3
`define DTC_CTRL_RANK_LO    8
`define DTC_CTRL_RANK_HI    10

// ----------------------------------------------------------------
// Parameter register fields
// ----------------------------------------------------------------
`define DTC_PAR_DELAY_LO    10
`define DTC_PAR_DELAY_HI    14

// ----------------------------------------------------------------
// Direct command register fields
// ----------------------------------------------------------------
`define DTC_CMD_PRE         28
`define DTC_CMD_ACT         27
`define DTC_CMD_RCW         26
`define DTC_CMD_WR          25
`define DTC_CMD_RD          24
`define DTC_CMD_MRS         23
`define DTC_CMD_RANK_LO     20
`define DTC_CMD_RANK_HI     22
`define DTC_CMD_BA_LO       16
`define DTC_CMD_BA_HI       19
`define DTC_CMD_ADDR_LO     0
`define DTC_CMD_ADDR_HI     15

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define DTC_ST_IMP_DONE     9
`define DTC_ST_SEQ_DONE     8
`define DTC_ST_ZQ_DONE      7
`define DTC_ST_PASS_LO      3
`define DTC_ST_PASS_HI      6
`define DTC_ST_STATE_LO     0
`define DTC_ST_STATE_HI     2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DTC_RST_CMD         32'h0000_0000
`define DTC_RST_DELAY       5'h00
`define DTC_RST_RANK        3'h0

`endif

// ---- rtl/ddr_start_training_pkg.sv ----
// Purpose: Types shared by the training/command block
// Assumes: Nothing
// Notes:   Codes of training states live in state_code
package ddr_start_training_pkg;

  typedef enum logic [2:0] {
    CMD_PRE,
    CMD_ACT,
    CMD_RCW,
    CMD_WR,
    CMD_RD,
    CMD_MRS
  } cmd_kind_e;

  typedef enum {
    TS_IDLE,
    TS_RD_DQS,
    TS_RCVEN,
    TS_WRLVL,
    TS_WR_DQS
  } start_training_state_e;

  function automatic logic [2:0] state_code(input start_training_state_e s);
    case (s)
      TS_IDLE:   state_code = 3'h0;
      TS_RD_DQS: state_code = 3'h1;
      TS_RCVEN:  state_code = 3'h2;
      TS_WRLVL:  state_code = 3'h3;
      TS_WR_DQS: state_code = 3'h4;
      default:   state_code = 3'h0;
    endcase
  endfunction

endpackage

// ---- rtl/dram_cmd_if.sv ----
// Purpose: Request path from the register side to the command issuer
// Assumes: One clock
// Notes:   done pulses in the same cycle as the command is on the pins
`timescale 1ns/100ps
interface dram_cmd_if;
  import ddr_start_training_pkg::*;
  logic        req;
  cmd_kind_e   kind;
  logic [2:0]  rank;
  logic [3:0]  bank;
  logic [15:0] addr;
  logic        done;

  modport source (output req, output kind, output rank, output bank, output addr,
                  input done);
  modport issuer (input req, input kind, input rank, input bank, input addr,
                  output done);
endinterface

// ---- rtl/dram_cmd_issue.sv ----
// Purpose: Drives one direct DRAM command onto the memory pins
// Assumes: Requester holds req until done
// Notes:   Pins stay idle (deselect) outside the issue cycle
`timescale 1ns/100ps
module dram_cmd_issue
  import ddr_start_training_pkg::*;
#(
  parameter int RANKS = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Request
  dram_cmd_if.issuer            cmd,
  // Memory pins
  output logic [RANKS-1:0]      cs_n_o,
  output logic                  ras_n_o,
  output logic                  cas_n_o,
  output logic                  we_n_o,
  output logic                  rcw_o,
  output logic [2:0]            bank_pins_o,
  output logic [15:0]           memory_address_pins_o
);

  logic issued_q;
  logic fire;

  assign fire     = cmd.req && !issued_q;
  assign cmd.done = issued_q;

  // ----------------------------------------------------------------
  // Issue
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      issued_q <= 1'b0;
    end else begin
      issued_q <= fire;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !fire) begin
      cs_n_o                <= '1;
      {ras_n_o, cas_n_o, we_n_o} <= 3'h7;
      rcw_o                 <= 1'b0;
      bank_pins_o           <= 3'h0;
      memory_address_pins_o <= 16'h0000;
    end else begin
      cs_n_o                <= ~(RANKS'(1) << cmd.rank);
      bank_pins_o           <= cmd.bank[2:0];
      memory_address_pins_o <= cmd.addr;
      rcw_o                 <= (cmd.kind == CMD_RCW);
      case (cmd.kind)
        CMD_PRE: {ras_n_o, cas_n_o, we_n_o} <= 3'h2;
        CMD_ACT: {ras_n_o, cas_n_o, we_n_o} <= 3'h3;
        CMD_WR:  {ras_n_o, cas_n_o, we_n_o} <= 3'h4;
        CMD_RD:  {ras_n_o, cas_n_o, we_n_o} <= 3'h5;
        CMD_MRS: {ras_n_o, cas_n_o, we_n_o} <= 3'h0;
        CMD_RCW: {ras_n_o, cas_n_o, we_n_o} <= 3'h0;
        default: {ras_n_o, cas_n_o, we_n_o} <= 3'h7;
      endcase
    end
  end

endmodule

// ---- rtl/start_training_seq.sv ----
// Purpose: Top-level training sequencer with step timer and pass flags
// Assumes: step_done_i pulses once per finished step
// Notes:   A step that times out counts as failed
`timescale 1ns/100ps
module start_training_seq
  import ddr_start_training_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [4:0] step_delay_i,
  // Training engine
  input  wire logic       step_done_i,
  input  wire logic       step_pass_i,
  // Status
  output logic [2:0]      training_state_o,
  output logic [3:0]      step_ok_o,
  output logic            training_sequence_done_o
);

  start_training_state_e state_q;
  start_training_state_e next_step;
  logic [31:0]  timer_q;
  logic [31:0]  reload;
  logic         advance;
  logic [1:0]   step_idx;

  assign reload           = 32'h1 << step_delay_i;
  assign advance          = (state_q != TS_IDLE) && (step_done_i || timer_q == 32'h1);
  assign training_state_o = state_code(state_q);
  assign step_idx         = 2'(training_state_o - 3'h1);

  always_comb begin
    case (state_q)
      TS_RD_DQS: next_step = TS_RCVEN;
      TS_RCVEN:  next_step = TS_WRLVL;
      TS_WRLVL:  next_step = TS_WR_DQS;
      default:   next_step = TS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Step sequencing and timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= TS_IDLE;
      timer_q <= 32'h0;
    end else if (start_i) begin
      state_q <= TS_RD_DQS;
      timer_q <= reload;
    end else if (advance) begin
      state_q <= next_step;
      timer_q <= reload;
    end else if (state_q != TS_IDLE) begin
      timer_q <= timer_q - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Result flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i || start_i) begin
      step_ok_o                <= 4'h0;
      training_sequence_done_o <= 1'b0;
    end else if (advance) begin
      if (step_done_i && step_pass_i) begin
        step_ok_o[step_idx] <= 1'b1;
      end
      if (state_q == TS_WR_DQS) begin
        training_sequence_done_o <= 1'b1;
      end
    end
  end

endmodule

// ---- rtl/ddr_start_training_cmd.sv ----
// Purpose: Training status and direct DRAM command block of one channel
// Assumes: APB slave, one clock, synchronous active-high reset
// Notes:   Every access takes one wait state
//
// Contract
// - New training command clears all status flags; the state field shows step one
// - Sequence-done flag cleared at launch, set at end
// - Impedance-cal flag cleared on issue, set when done
// - Long ZQ flag cleared on issue, set when done
// - Write data-strobe pass flag, cleared by training
// - Write leveling pass flag, cleared by training
// - Receive-enable pass flag, cleared by training
// - Read data-strobe pass flag, cleared by training
// - Low three status bits show training state
// - Command writes ignored after init done
// - Valid bits 28 to 23 select command
// - Hardware clears bits 26 to 23 after issue
// - Bits 22:20 select destination rank
// - Bits 18:16 drive the bank pins
// - Bits 15:0 drive the address pins
// - Registered config write only on supporting variants
// - Start_training bit starts sequence for chosen rank
// - Power-of-two step timer advances and reloads
`timescale 1ns/100ps
`include "ddr_start_training_map.svh"
module ddr_start_training_cmd
  import ddr_start_training_pkg::*;
#(
  parameter int RANKS       = 8,
  parameter bit RDIMM_SUPPORT = 1'b1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic                  pready_o,
  output logic [31:0]           prdata_o,
  output logic                  pslverr_o,
  // Training engine
  output logic                  start_training_start_o,
  output logic [2:0]            start_training_rank_o,
  output logic [2:0]            start_training_step_o,
  input  wire logic             step_done_i,
  input  wire logic             step_pass_i,
  // Calibration engines
  output logic                  impedance_cal_req_o,
  input  wire logic             impedance_cal_done_i,
  output logic                  zq_long_cal_req_o,
  input  wire logic             zq_long_cal_done_i,
  // Memory pins
  output logic [RANKS-1:0]      cs_n_o,
  output logic                  ras_n_o,
  output logic                  cas_n_o,
  output logic                  we_n_o,
  output logic                  rcw_o,
  output logic [2:0]            bank_pins_o,
  output logic [15:0]           memory_address_pins_o
);

  dram_cmd_if cmd_bus ();

  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] rd_val;

  logic [31:0] direct_dram_command_q;
  logic        cmd_req_q;
  logic        init_done_q;
  logic [2:0]  start_training_rank_q;
  logic [4:0]  training_step_timeout_q;
  logic        impedance_cal_done_q;
  logic        zq_long_cal_done_q;

  logic        wr_ctrl;
  logic        wr_cmd;
  logic        start_training;
  logic        start_imp;
  logic        start_zq;
  logic [31:0] cmd_wval;

  logic [2:0]  training_state;
  logic [3:0]  step_ok;
  logic        training_sequence_done;
  logic [31:0] training_init_status;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Highest valid bit wins when software sets more than one
  function automatic cmd_kind_e pick_kind(input logic [31:0] c);
    if (c[`DTC_CMD_PRE])      pick_kind = CMD_PRE;
    else if (c[`DTC_CMD_ACT]) pick_kind = CMD_ACT;
    else if (c[`DTC_CMD_RCW]) pick_kind = CMD_RCW;
    else if (c[`DTC_CMD_WR])  pick_kind = CMD_WR;
    else if (c[`DTC_CMD_RD])  pick_kind = CMD_RD;
    else                      pick_kind = CMD_MRS;
  endfunction

  function automatic logic any_valid(input logic [31:0] c);
    any_valid = |c[`DTC_CMD_PRE:`DTC_CMD_MRS];
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign access = psel_i && penable_i;
  assign wr_en  = access && pready_o && pwrite_i;
  assign rd_en  = access && !pready_o;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0;
    case (paddr_i)
      `DTC_OFF_CTRL: begin
        rd_val[`DTC_CTRL_INIT_DONE]                 = init_done_q;
        rd_val[`DTC_CTRL_RANK_HI:`DTC_CTRL_RANK_LO] = start_training_rank_q;
      end
      `DTC_OFF_PARAMS: begin
        rd_val[`DTC_PAR_DELAY_HI:`DTC_PAR_DELAY_LO] = training_step_timeout_q;
      end
      `DTC_OFF_CMD:    rd_val = direct_dram_command_q;
      `DTC_OFF_STATUS: rd_val = training_init_status;
      default:         hit    = 1'b0;
    endcase
  end

  // One wait state so that read data come from a register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= rd_en;
      pslverr_o <= rd_en && !hit;
      if (rd_en && !pwrite_i) begin
        prdata_o <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and parameter registers
  // ----------------------------------------------------------------
  assign wr_ctrl        = wr_en && hit && paddr_i == `DTC_OFF_CTRL;
  assign start_training = wr_ctrl && pwdata_i[`DTC_CTRL_START_TRAINING];
  assign start_imp      = wr_ctrl && pwdata_i[`DTC_CTRL_IMP_CAL];
  assign start_zq       = wr_ctrl && pwdata_i[`DTC_CTRL_ZQ_CAL];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      init_done_q           <= 1'b0;
      start_training_rank_q <= `DTC_RST_RANK;
    end else if (wr_ctrl) begin
      init_done_q           <= pwdata_i[`DTC_CTRL_INIT_DONE];
      start_training_rank_q <= pwdata_i[`DTC_CTRL_RANK_HI:`DTC_CTRL_RANK_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      training_step_timeout_q <= `DTC_RST_DELAY;
    end else if (wr_en && hit && paddr_i == `DTC_OFF_PARAMS) begin
      training_step_timeout_q <= pwdata_i[`DTC_PAR_DELAY_HI:`DTC_PAR_DELAY_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      start_training_start_o       <= 1'b0;
      impedance_cal_req_o <= 1'b0;
      zq_long_cal_req_o   <= 1'b0;
    end else begin
      start_training_start_o       <= start_training;
      impedance_cal_req_o <= start_imp;
      zq_long_cal_req_o   <= start_zq;
    end
  end

  assign start_training_rank_o = start_training_rank_q;
  assign start_training_step_o = training_state;

  // ----------------------------------------------------------------
  // Calibration flags (a completion in the clearing cycle wins)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      impedance_cal_done_q <= 1'b0;
    end else if (impedance_cal_done_i) begin
      impedance_cal_done_q <= 1'b1;
    end else if (start_imp || start_training) begin
      impedance_cal_done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      zq_long_cal_done_q <= 1'b0;
    end else if (zq_long_cal_done_i) begin
      zq_long_cal_done_q <= 1'b1;
    end else if (start_zq || start_training) begin
      zq_long_cal_done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Training sequencer
  // ----------------------------------------------------------------
  start_training_seq u_seq (
    .clk_i                    (clk_i),
    .srst_i                   (srst_i),
    .start_i                  (start_training),
    .step_delay_i             (training_step_timeout_q),
    .step_done_i              (step_done_i),
    .step_pass_i              (step_pass_i),
    .training_state_o         (training_state),
    .step_ok_o                (step_ok),
    .training_sequence_done_o (training_sequence_done)
  );

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb begin
    training_init_status                                 = 32'h0;
    training_init_status[`DTC_ST_IMP_DONE]               = impedance_cal_done_q;
    training_init_status[`DTC_ST_SEQ_DONE]               = training_sequence_done;
    training_init_status[`DTC_ST_ZQ_DONE]                = zq_long_cal_done_q;
    training_init_status[`DTC_ST_PASS_HI:`DTC_ST_PASS_LO] = step_ok;
    training_init_status[`DTC_ST_STATE_HI:`DTC_ST_STATE_LO] = training_state;
  end

  // ----------------------------------------------------------------
  // Direct command register
  // ----------------------------------------------------------------
  assign wr_cmd = wr_en && hit && paddr_i == `DTC_OFF_CMD && !init_done_q;

  always_comb begin
    cmd_wval = pwdata_i & 32'h1fff_ffff;
    if (!RDIMM_SUPPORT) begin
      cmd_wval[`DTC_CMD_RCW] = 1'b0;
    end
  end

  // A new write in the completion cycle takes precedence over the clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      direct_dram_command_q <= `DTC_RST_CMD;
      cmd_req_q             <= 1'b0;
    end else if (wr_cmd) begin
      direct_dram_command_q <= cmd_wval;
      cmd_req_q             <= any_valid(cmd_wval);
    end else if (cmd_bus.done) begin
      cmd_req_q <= 1'b0;
      case (cmd_bus.kind)
        CMD_RCW: direct_dram_command_q[`DTC_CMD_RCW] <= 1'b0;
        CMD_WR:  direct_dram_command_q[`DTC_CMD_WR]  <= 1'b0;
        CMD_RD:  direct_dram_command_q[`DTC_CMD_RD]  <= 1'b0;
        CMD_MRS: direct_dram_command_q[`DTC_CMD_MRS] <= 1'b0;
        default: direct_dram_command_q[`DTC_CMD_PRE] <= direct_dram_command_q[`DTC_CMD_PRE];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request to the issuer
  // ----------------------------------------------------------------
  assign cmd_bus.req  = cmd_req_q;
  assign cmd_bus.kind = pick_kind(direct_dram_command_q);
  assign cmd_bus.rank = direct_dram_command_q[`DTC_CMD_RANK_HI:`DTC_CMD_RANK_LO];
  assign cmd_bus.bank = direct_dram_command_q[`DTC_CMD_BA_HI:`DTC_CMD_BA_LO];
  assign cmd_bus.addr = direct_dram_command_q[`DTC_CMD_ADDR_HI:`DTC_CMD_ADDR_LO];

  dram_cmd_issue #(
    .RANKS (RANKS)
  ) u_issue (
    .clk_i                 (clk_i),
    .srst_i                (srst_i),
    .cmd                   (cmd_bus),
    .cs_n_o                (cs_n_o),
    .ras_n_o               (ras_n_o),
    .cas_n_o               (cas_n_o),
    .we_n_o                (we_n_o),
    .rcw_o                 (rcw_o),
    .bank_pins_o           (bank_pins_o),
    .memory_address_pins_o (memory_address_pins_o)
  );

endmodule

// ---- sim/ddr_start_training_cmd_asserts.sv ----
// Purpose: Port checker of the training/command block
// Assumes: One clock, sync reset
// Notes:   Bound at the foot
`timescale 1ns/100ps
module ddr_start_training_cmd_asserts #(
  parameter int RANKS = 8
) (
  // Clock, reset, APB
  input wire logic             clk_i,
  input wire logic             srst_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [11:0]      paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic             pready_o,
  // Training and pins
  input wire logic             start_training_start_o,
  input wire logic [2:0]       start_training_step_o,
  input wire logic [RANKS-1:0] cs_n_o,
  input wire logic             ras_n_o,
  input wire logic             cas_n_o,
  input wire logic             we_n_o,
  input wire logic             rcw_o,
  input wire logic [2:0]       bank_pins_o,
  input wire logic [15:0]      memory_address_pins_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic wr;
  logic idle;
  assign wr   = psel_i && penable_i && pready_o && pwrite_i;
  assign idle = (cs_n_o == '1);

  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  a_ready_once: assert property (pready_o |=> !pready_o) else $error("pready stuck");
  a_start_step: assert property (start_training_start_o |-> start_training_step_o == 3'h1)
    else $error("training did not begin at step one");
  a_start_cause: assert property (start_training_start_o |-> $past(wr && paddr_i == 12'h050 && pwdata_i[0]))
    else $error("training start without start_training write");
  a_state_range: assert property (start_training_step_o <= 3'h4) else $error("bad state code");
  a_cmd_cause: assert property (!idle |-> $past(wr && paddr_i == 12'h060, 2))
    else $error("command without register write");
  a_cs_single: assert property (!idle |-> $onehot(~cs_n_o) ##1 idle)
    else $error("select not one rank for one cycle");
  a_pins_idle: assert property (idle |-> {ras_n_o, cas_n_o, we_n_o, rcw_o} == 4'he &&
    bank_pins_o == 3'h0 && memory_address_pins_o == 16'h0) else $error("pins not idle");
  a_rcw_code: assert property (rcw_o |-> !idle && {ras_n_o, cas_n_o, we_n_o} == 3'h0)
    else $error("config write code wrong");
  c_start: cover property (start_training_start_o);
  c_rcw: cover property (rcw_o);
  c_last: cover property (start_training_step_o == 3'h4);
endmodule

bind ddr_start_training_cmd ddr_start_training_cmd_asserts #(.RANKS(RANKS)) chk_i (.clk_i, .srst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .start_training_start_o, .start_training_step_o,
  .cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .rcw_o, .bank_pins_o, .memory_address_pins_o);

// ---- sim/start_training_partner.sv ----
// Purpose: Training and calibration engines beside the block
// Assumes: Step state visible on start_training_step_i
// Notes:   stall_i withholds step completion so the timer ends steps
`timescale 1ns/100ps
module start_training_partner (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // From block
  input  wire logic [2:0] start_training_step_i,
  input  wire logic       impedance_cal_req_i,
  input  wire logic       zq_long_cal_req_i,
  input  wire logic [3:0] pass_i,
  input  wire logic       stall_i,
  // To block
  output logic            step_done_o,
  output logic            step_pass_o,
  output logic            impedance_cal_done_o,
  output logic            zq_long_cal_done_o
);
  logic [2:0] cnt_q;
  logic [1:0] imp_q;
  logic [1:0] zq_q;
  always_ff @(posedge clk_i) begin
    step_done_o <= 1'b0;
    if (srst_i || start_training_step_i == 3'h0 || step_done_o) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h2 && !stall_i) begin
        step_done_o <= 1'b1;
        step_pass_o <= pass_i[start_training_step_i[1:0] - 2'h1];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    imp_q <= srst_i ? 2'h0 : {imp_q[0], impedance_cal_req_i};
    zq_q  <= srst_i ? 2'h0 : {zq_q[0], zq_long_cal_req_i};
  end
  assign impedance_cal_done_o = imp_q[1];
  assign zq_long_cal_done_o   = zq_q[1];
endmodule

// ---- sim/tb_ddr_start_training_cmd.sv ----
// Purpose: Self-checking bench of the training/command block
// Assumes: One wait state APB slave
// Notes:   Step timeout set to 2^3 cycles
`timescale 1ns/100ps
module tb_ddr_start_training_cmd;
  logic clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat, seen;
  logic start_training_start_o, step_done_i, step_pass_i, impedance_cal_req_o, impedance_cal_done_i;
  logic zq_long_cal_req_o, zq_long_cal_done_i, ras_n_o, cas_n_o, we_n_o, rcw_o, perr, stall;
  logic [2:0] start_training_rank_o, start_training_step_o, bank_pins_o;
  logic [3:0] pass;
  logic [7:0] cs_n_o;
  logic [15:0] memory_address_pins_o;
  int fails, check_count;
  logic [3:0] enc [6] = '{4'h2, 4'h3, 4'h8, 4'h4, 4'h5, 4'h0};

  ddr_start_training_cmd uut (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .prdata_o, .pslverr_o, .start_training_start_o, .start_training_rank_o, .start_training_step_o,
    .step_done_i, .step_pass_i, .impedance_cal_req_o, .impedance_cal_done_i,
    .zq_long_cal_req_o, .zq_long_cal_done_i, .cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .rcw_o,
    .bank_pins_o, .memory_address_pins_o);
  start_training_partner eng (.clk_i, .srst_i, .start_training_step_i(start_training_step_o),
    .impedance_cal_req_i(impedance_cal_req_o), .zq_long_cal_req_i(zq_long_cal_req_o),
    .pass_i(pass), .stall_i(stall), .step_done_o(step_done_i), .step_pass_o(step_pass_i),
    .impedance_cal_done_o(impedance_cal_done_i), .zq_long_cal_done_o(zq_long_cal_done_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (cs_n_o !== 8'hff) begin
    seen = {1'b0, rcw_o, ras_n_o, cas_n_o, we_n_o, cs_n_o, bank_pins_o, memory_address_pins_o};
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wait_st(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h064, 32'h0);
      n++;
    end while (rdat[b] !== 1'b1 && n < 40);
  endtask
  task test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    apb(1'b0, 12'h060, 32'h0);
    chk("cmd reset", 32'h0, rdat);
    apb(1'b0, 12'h064, 32'h0);
    chk("status reset", 32'h0, rdat);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], perr});
  endtask
  task t_cal;
    apb(1'b1, 12'h050, 32'h2);
    wait_st(9);
    apb(1'b1, 12'h050, 32'h4);
    wait_st(7);
    chk("cal flags", 32'h280, rdat);
    apb(1'b1, 12'h050, 32'h2);
    apb(1'b0, 12'h064, 32'h0);
    chk("cal clear", 32'h80, rdat);
    wait_st(9);
  endtask
  task t_start_training;
    apb(1'b1, 12'h058, 32'h0c00);
    apb(1'b1, 12'h050, 32'h501);
    wait_st(8);
    chk("pass mix", 32'h150, rdat);
    chk("rank", 32'h5, {29'h0, start_training_rank_o});
    stall <= 1'b1;
    pass <= 4'hf;
    apb(1'b1, 12'h050, 32'h501);
    apb(1'b0, 12'h064, 32'h0);
    chk("restart", 32'h1, rdat);
    wait_st(8);
    chk("timeouts", 32'h100, rdat);
  endtask
  task t_cmd;
    logic [31:0] d;
    for (int k = 0; k < 6; k++) begin
      d = {3'h0, 6'h20 >> k, 3'(k), 4'h5, 16'h1230 + 16'(k)};
      seen = 32'h0;
      apb(1'b1, 12'h060, d);
      repeat (4) @(posedge clk_i);
      chk("pins", {1'b0, enc[k], ~(8'h1 << k), 3'h5, 16'h1230 + 16'(k)}, seen);
      apb(1'b0, 12'h060, 32'h0);
      chk("clear", k < 2 ? d : d & ~(32'h1000_0000 >> k), rdat);
    end
  endtask
  task t_lock;
    apb(1'b1, 12'h050, 32'h8);
    seen = 32'h0;
    apb(1'b1, 12'h060, 32'h0100_0000);
    repeat (4) @(posedge clk_i);
    chk("locked pins", 32'h0, seen);
    apb(1'b0, 12'h060, 32'h0);
    chk("locked reg", 32'h0055_1235, rdat);
    apb(1'b1, 12'h064, 32'hffff_ffff);
    apb(1'b0, 12'h064, 32'h0);
    chk("status ro", 32'h100, rdat);
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {fails, check_count} = '0;
    srst_i = 1'b1;
    stall = 1'b0;
    pass = 4'ha;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset;
    t_cal;
    t_start_training;
    t_cmd;
    t_lock;
    test_done;
  end
  initial begin
    #100us;
    fails++;
    test_done;
  end
endmodule
